// >>> src/lcd_host_port.v
// Character LCD controller host port: instruction decode and text RAM.
// Assumes an APB master in the pclk domain; software emulates the parallel bus.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "lcd_port_map.vh"
module lcd_host_port #(
    parameter RAM_DEPTH = `TEXT_RAM_DEPTH
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Power-down pin
    input  wire        power_down_pin,
    // Status
    output reg         display_active,
    output reg         cursor_visible,
    output reg         icon_mode,
    output reg         powered_down
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg        width8_reg;
    reg        two_line_reg;
    reg        volt_sel_reg;
    reg        display_on_reg;
    reg        cursor_on_reg;
    reg        blink_reg;
    reg        entry_incr_reg;
    reg        entry_shift_reg;
    reg        icon_only_select_reg;
    reg        first_write_done_reg;
    reg  [6:0] text_addr_reg;
    reg  [7:0] last_data_reg;
    reg  [7:0] display_text_ram [0:RAM_DEPTH-1];
    reg        down_pin_reg;
    integer    i;

    // Last text cell; the address wraps here in either direction
    localparam [31:0] LAST_ADDR = RAM_DEPTH - 1;

    // ------------------------------------------------------------
    // Bus access decode
    // ------------------------------------------------------------
    wire       access  = psel && penable && pready;
    wire       wr      = access && pwrite;
    wire       bus_acc = wr && (paddr == `OFF_BUS_ACCESS) && !pwdata[`ACC_RW_BIT];
    wire       byte_strobe;
    wire [7:0] byte_value;
    wire       byte_reg_select;
    wire       waiting_low;
    wire       single_access;
    wire       mode4;

    // Before any write the bus is wide; the very first write is whole
    assign single_access = !first_write_done_reg;
    assign mode4         = !width8_reg && !single_access;

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------
    nibble_assembler assembler (
        .pclk              (pclk),
        .presetn           (presetn),
        .four_bit_mode     (mode4),
        .access_strobe     (bus_acc),
        .access_bus        (pwdata[7:0]),
        .access_reg_select (pwdata[`ACC_REG_SELECT_BIT]),
        .byte_strobe       (byte_strobe),
        .byte_value        (byte_value),
        .byte_reg_select   (byte_reg_select),
        .waiting_low       (waiting_low)
    );

    // ------------------------------------------------------------
    // Address stepping and command decode
    // ------------------------------------------------------------
    function [6:0] next_addr;
        input [6:0] a;
        input       incr;
        begin
            if (incr)
                next_addr = (a == LAST_ADDR[6:0]) ? 7'h00 : a + 7'h01;
            else
                next_addr = (a == 7'h00) ? LAST_ADDR[6:0] : a - 7'h01;
        end
    endfunction

    function is_function_cmd;
        input [7:0] b;
        begin
            is_function_cmd = (b[7:6] == 2'b00) && b[`CMD_FUNCTION_BIT];
        end
    endfunction

    function is_display_cmd;
        input [7:0] b;
        begin
            is_display_cmd = (b[7:4] == 4'h0) && b[`CMD_DISPLAY_BIT];
        end
    endfunction

    function is_entry_cmd;
        input [7:0] b;
        begin
            is_entry_cmd = (b[7:3] == 5'h00) && b[`CMD_ENTRY_BIT];
        end
    endfunction

    function is_clear_cmd;
        input [7:0] b;
        begin
            is_clear_cmd = (b == 8'h01);
        end
    endfunction

    // ------------------------------------------------------------
    // Instruction execution
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width8_reg           <= 1'b1;
            two_line_reg         <= 1'b0;
            volt_sel_reg         <= 1'b0;
            display_on_reg       <= 1'b0;
            cursor_on_reg        <= 1'b0;
            blink_reg            <= 1'b0;
            entry_incr_reg       <= `RST_ENTRY_INCR;
            entry_shift_reg      <= 1'b0;
            first_write_done_reg <= 1'b0;
            text_addr_reg        <= `RST_ADDR;
            last_data_reg        <= 8'h00;
            for (i = 0; i < RAM_DEPTH; i = i + 1)
                display_text_ram[i] <= `TEXT_BLANK;
        end else begin
            if (byte_strobe) begin
                first_write_done_reg <= 1'b1;
                if (byte_reg_select) begin
                    display_text_ram[text_addr_reg] <= byte_value;
                    last_data_reg <= byte_value;
                    text_addr_reg <= next_addr(text_addr_reg, entry_incr_reg);
                end else if (is_function_cmd(byte_value)) begin
                    width8_reg   <= byte_value[`FN_WIDTH8_BIT];
                    two_line_reg <= byte_value[`FN_TWO_LINE_BIT];
                    volt_sel_reg <= byte_value[`FN_VOLT_BIT];
                end else if (is_display_cmd(byte_value)) begin
                    display_on_reg <= byte_value[`DC_DISPLAY_BIT];
                    cursor_on_reg  <= byte_value[`DC_CURSOR_BIT];
                    blink_reg      <= byte_value[`DC_BLINK_BIT];
                end else if (is_entry_cmd(byte_value)) begin
                    entry_incr_reg  <= byte_value[`EM_INCR_BIT];
                    entry_shift_reg <= byte_value[`EM_SHIFT_BIT];
                end else if (is_clear_cmd(byte_value)) begin
                    for (i = 0; i < RAM_DEPTH; i = i + 1)
                        display_text_ram[i] <= `TEXT_BLANK;
                    text_addr_reg  <= `RST_ADDR;
                    entry_incr_reg <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Power control and status outputs
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icon_only_select_reg <= 1'b0;
            down_pin_reg         <= 1'b0;
            display_active       <= 1'b0;
            cursor_visible       <= 1'b0;
            icon_mode            <= 1'b0;
            powered_down         <= 1'b0;
        end else begin
            if (wr && paddr == `OFF_POWER_CTRL)
                icon_only_select_reg <= pwdata[`PWR_ICON_BIT];
            down_pin_reg   <= power_down_pin;
            powered_down   <= power_down_pin;
            // Power-down overrides every mode so nothing else draws current
            display_active <= display_on_reg && !power_down_pin;
            cursor_visible <= display_on_reg && cursor_on_reg && !icon_only_select_reg
                              && !power_down_pin;
            icon_mode      <= icon_only_select_reg && !power_down_pin;
        end
    end

    // ------------------------------------------------------------
    // APB slave: one wait-free access phase
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                `OFF_BUS_ACCESS:   prdata <= {30'h0, waiting_low, !width8_reg};
                `OFF_CONFIG_STATE: prdata <= {24'h0, blink_reg, cursor_on_reg, display_on_reg,
                                              entry_shift_reg, entry_incr_reg, volt_sel_reg,
                                              two_line_reg, width8_reg};
                `OFF_CURSOR_STATE: prdata <= {25'h0, text_addr_reg};
                `OFF_LAST_DATA:    prdata <= {24'h0, last_data_reg};
                `OFF_POWER_CTRL:   prdata <= {30'h0, down_pin_reg, icon_only_select_reg};
                default:           pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // lcd_host_port

// >>> src/lcd_port_map.vh
// Constants for the character LCD parallel host port: offsets, fields, resets.
// Assumes inclusion by the host port module and the testbench; definitions only.
`ifndef LCD_PORT_MAP_VH
`define LCD_PORT_MAP_VH

// ------------------------------------------------------------
// APB register offsets (byte addresses)
// ------------------------------------------------------------
`define OFF_BUS_ACCESS    12'h000
`define OFF_CONFIG_STATE  12'h004
`define OFF_CURSOR_STATE  12'h008
`define OFF_LAST_DATA     12'h00C
`define OFF_POWER_CTRL    12'h010

// ------------------------------------------------------------
// Bus access word fields
// ------------------------------------------------------------
`define ACC_DATA_LSB      0
`define ACC_REG_SELECT_BIT 8
`define ACC_RW_BIT        9

// ------------------------------------------------------------
// Instruction encodings (upper bits identify the command)
// ------------------------------------------------------------
`define CMD_FUNCTION_BIT  5
`define CMD_DISPLAY_BIT   3
`define CMD_ENTRY_BIT     2
`define FN_WIDTH8_BIT     4
`define FN_TWO_LINE_BIT   2
`define FN_VOLT_BIT       0
`define DC_DISPLAY_BIT    2
`define DC_CURSOR_BIT     1
`define DC_BLINK_BIT      0
`define EM_INCR_BIT       1
`define EM_SHIFT_BIT      0
`define PWR_ICON_BIT      0

// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define RST_ADDR          7'h00
`define RST_ENTRY_INCR    1'b1
`define TEXT_RAM_DEPTH    80
`define TEXT_BLANK        8'h20

`endif

// >>> src/nibble_assembler.v
// Assembles host accesses into whole bytes, one access in 8-bit mode,
// two accesses high nibble first in 4-bit mode.
// Assumes one access per cycle at most, presented as a one-cycle strobe.
`timescale 1ns/100ps
module nibble_assembler (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Mode
    input  wire       four_bit_mode,
    // Access in
    input  wire       access_strobe,
    input  wire [7:0] access_bus,
    input  wire       access_reg_select,
    // Byte out
    output reg        byte_strobe,
    output reg  [7:0] byte_value,
    output reg        byte_reg_select,
    output reg        waiting_low
);
    reg [3:0] high_nibble_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_nibble_reg <= 4'h0;
            waiting_low     <= 1'b0;
            byte_strobe     <= 1'b0;
            byte_value      <= 8'h00;
            byte_reg_select <= 1'b0;
        end else begin
            byte_strobe <= 1'b0;
            if (access_strobe) begin
                if (!four_bit_mode) begin
                    byte_strobe <= 1'b1;
                    byte_value  <= access_bus;
                    byte_reg_select <= access_reg_select;
                end else if (!waiting_low) begin
                    high_nibble_reg <= access_bus[7:4];
                    waiting_low     <= 1'b1;
                end else begin
                    byte_strobe <= 1'b1;
                    byte_value  <= {high_nibble_reg, access_bus[7:4]};
                    byte_reg_select <= access_reg_select;
                    waiting_low <= 1'b0;
                end
            end
        end
    end
endmodule // nibble_assembler

// >>> tb/host_cpu_model.sv
// Host processor model: APB master that emulates the parallel bus.
// Assumes a slave that answers with pready; waits are cut by the bench.
`timescale 1ns/100ps
module host_cpu_model (
    // Clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // APB master
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input  wire  [31:0] prdata,
    input  wire         pready,
    input  wire         pslverr
);
    // ----------------------------------------
    // Transfer; never sends generator or direct-mode commands
    // ----------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        // Decode lags the access edge by two cycles
        repeat (4) @(posedge pclk);
    endtask
endmodule // host_cpu_model

// >>> tb/lcd_port_checker_assertions.sv
// Checker for the LCD host port: APB answer timing and status outputs.
// Assumes binding to lcd_host_port; sees only its ports.
`timescale 1ns/100ps
module lcd_port_checker (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        pslverr,
    input wire [31:0] prdata,
    // Power and status
    input wire        power_down_pin,
    input wire        display_active,
    input wire        cursor_visible,
    input wire        icon_mode,
    input wire        powered_down
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_access)
        else $error("no answer in the access cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside access");
    a_down_follows_pin: assert property (powered_down == $past(power_down_pin))
        else $error("powered_down does not follow the pin");
    a_down_all_quiet: assert property (powered_down |-> !display_active && !icon_mode)
        else $error("output active while powered down");
    a_cursor_needs_disp: assert property (cursor_visible |-> display_active)
        else $error("cursor visible with display off");
    a_icon_no_cursor: assert property (icon_mode |-> !cursor_visible)
        else $error("cursor visible in icon mode");
endmodule // lcd_port_checker

bind lcd_host_port lcd_port_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .power_down_pin(power_down_pin), .display_active(display_active),
    .cursor_visible(cursor_visible), .icon_mode(icon_mode), .powered_down(powered_down));

// >>> tb/testbench.sv
// Testbench for the LCD host port: start-up sequence, commands, power options.
// Assumes the host model drives APB; expectations follow the register map header.
`timescale 1ns/100ps
`include "lcd_port_map.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (x)); end end
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        power_down_pin = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        display_active, cursor_visible, icon_mode, powered_down, e;
    int          errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    always #2 pclk = ~pclk;
    host_cpu_model cpu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    lcd_host_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_down_pin(power_down_pin), .display_active(display_active),
        .cursor_visible(cursor_visible), .icon_mode(icon_mode), .powered_down(powered_down));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        cpu.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        cpu.xfer(1'b0, a, 32'h0, q, e);
        `CHK(q & m, x)
        `CHK(e, 1'b0)
    endtask
    task automatic nib(input logic [7:0] b, input logic sel);
        wr(`OFF_BUS_ACCESS, {23'h0, sel, b[7:4], 4'h0});
        wr(`OFF_BUS_ACCESS, {23'h0, sel, b[3:0], 4'h0});
    endtask
    task automatic results;
        $display("tests=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 220 cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFF_BUS_ACCESS, 32'h3, 32'h0);
        rd(`OFF_CONFIG_STATE, 32'h9, 32'h9);
        wr(`OFF_BUS_ACCESS, 32'h20);
        rd(`OFF_BUS_ACCESS, 32'h3, 32'h1);
        wr(`OFF_BUS_ACCESS, 32'h20);
        rd(`OFF_BUS_ACCESS, 32'h3, 32'h3);
        wr(`OFF_BUS_ACCESS, 32'h00);
        rd(`OFF_BUS_ACCESS, 32'h3, 32'h1);
        rd(`OFF_CONFIG_STATE, 32'h7, 32'h0);
        nib(8'h0E, 1'b0);
        `CHK({display_active, cursor_visible}, 2'b11)
        rd(`OFF_CURSOR_STATE, 32'h7F, 32'h0);
        nib(8'h06, 1'b0);
        rd(`OFF_CONFIG_STATE, 32'h18, 32'h08);
        nib(8'h50, 1'b1);
        rd(`OFF_LAST_DATA, 32'hFF, 32'h50);
        rd(`OFF_CURSOR_STATE, 32'h7F, 32'h1);
        nib(8'h48, 1'b1);
        rd(`OFF_CURSOR_STATE, 32'h7F, 32'h2);
        wr(`OFF_BUS_ACCESS, 32'h2F0);
        rd(`OFF_BUS_ACCESS, 32'h3, 32'h1);
        power_down_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK({powered_down, display_active}, 2'b10)
        rd(`OFF_POWER_CTRL, 32'h2, 32'h2);
        power_down_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(display_active, 1'b1)
        wr(`OFF_POWER_CTRL, 32'h1);
        `CHK({icon_mode, cursor_visible}, 2'b10)
        nib(8'h08, 1'b0);
        `CHK(display_active, 1'b0)
        power_down_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK({powered_down, icon_mode, display_active}, 3'b100)
        cpu.xfer(1'b0, 12'h0FC, 32'h0, q, e);
        `CHK({e, q}, 33'h100000000)
        results();
    end
endmodule // testbench
